// File: leac_pkg.sv
// Shared constants and types for the logic element arithmetic chain.
// Assumes one clock domain; every file refers to items as leac_pkg::name.
package leac_pkg;

  // ****************************************************************
  // Geometry of one logic array block
  // ****************************************************************
  localparam int LEAC_ELEMENTS = 10;  // Logic elements per block
  localparam int LEAC_DATA_W = 4;  // Local data inputs per element
  localparam int LEAC_MASK_W = 16;  // Lookup table contents per element
  localparam int LEAC_MID_ELEMENT = 4;  // Index of the fifth element, mid-block carry point
  localparam int LEAC_LAST_ELEMENT = 9;  // Index of the tenth element, block carry out

  // ****************************************************************
  // Data input positions inside an element
  // ****************************************************************
  localparam int LEAC_IN_A = 0;  // Operand A, or lookup table chain input
  localparam int LEAC_IN_B = 1;  // Operand B
  localparam int LEAC_IN_C = 2;
  localparam int LEAC_IN_D = 3;  // Replaced by the flop output when packed

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic LEAC_FLOP_RST = 1'h0;
  localparam logic [LEAC_ELEMENTS-1:0] LEAC_RESULT_RST = 10'h000;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [0:0] {
    LEAC_MODE_NORMAL = 1'b0,
    LEAC_MODE_ARITH = 1'b1
  } leac_mode_e;

endpackage : leac_pkg

// File: leac_element.sv
// One logic element: lookup table, dual-carry arithmetic stage and flop.
// Assumes the block above supplies the shared clock, clear and enable.
`timescale 1ns/100ps

module leac_element (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire leac_pkg::leac_mode_e mode_in,
  input wire logic sub_in,
  input wire logic [leac_pkg::LEAC_MASK_W-1:0] lut_mask_in,
  input wire logic [leac_pkg::LEAC_DATA_W-1:0] data_in,
  input wire logic lut_chain_in,
  input wire logic lut_chain_sel_in,
  input wire logic pack_en_in,
  input wire logic reg_chain_in,
  input wire logic reg_chain_sel_in,
  input wire logic chain_start_in,
  input wire logic carry_in_zero_path_in,
  input wire logic carry_in_one_path_in,
  input wire logic block_carry_in,
  output logic comb_out,
  output logic reg_out,
  output logic carry_out_zero_path_out,
  output logic carry_out_one_path_out
);

  logic flop_q;
  logic op_a;
  logic op_b;
  logic cin_zero;
  logic cin_one;
  logic sum_zero;
  logic sum_one;
  logic [3:0] lut_idx;

  // ****************************************************************
  // Input steering
  // ****************************************************************
  // Operand A comes from the previous element's table when cascading
  assign op_a = lut_chain_sel_in ? lut_chain_in : data_in[leac_pkg::LEAC_IN_A];
  // Packed flop feeds its own table through the D input
  assign lut_idx = {(pack_en_in ? flop_q : data_in[leac_pkg::LEAC_IN_D]),
                    data_in[leac_pkg::LEAC_IN_C], data_in[leac_pkg::LEAC_IN_B], op_a};
  // Subtraction inverts every B bit
  assign op_b = data_in[leac_pkg::LEAC_IN_B] ^ sub_in;
  // Only a chain start takes its carry from the add/subtract control
  assign cin_zero = chain_start_in ? sub_in : carry_in_zero_path_in;
  assign cin_one = chain_start_in ? sub_in : carry_in_one_path_in;

  // ****************************************************************
  // Both carry outcomes in parallel
  // ****************************************************************
  assign sum_zero = op_a ^ op_b ^ cin_zero;
  assign sum_one = op_a ^ op_b ^ cin_one;

  // Mode decides table or selected sum, and whether carries run
  always_comb begin
    unique case (mode_in)
      leac_pkg::LEAC_MODE_ARITH: begin
        comb_out = block_carry_in ? sum_one : sum_zero;
        carry_out_zero_path_out = (op_a & op_b) | (cin_zero & (op_a ^ op_b));
        carry_out_one_path_out = (op_a & op_b) | (cin_one & (op_a ^ op_b));
      end
      leac_pkg::LEAC_MODE_NORMAL: begin
        comb_out = lut_mask_in[lut_idx];
        carry_out_zero_path_out = 1'b0;
        carry_out_one_path_out = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Storage flop, from table result or register chain
  // ****************************************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flop_q <= leac_pkg::LEAC_FLOP_RST;
    end else if (clk_en_in) begin
      flop_q <= reg_chain_sel_in ? reg_chain_in : comb_out;
    end
  end

  assign reg_out = flop_q;

  // Normal mode ignores both parallel carries
  property p_normal_no_carry;
    @(posedge clock_in) disable iff (!resetn_in)
      (mode_in == leac_pkg::LEAC_MODE_NORMAL) |->
        (!carry_out_zero_path_out && !carry_out_one_path_out && comb_out == lut_mask_in[lut_idx]);
  endproperty
  a_normal_no_carry: assert property (p_normal_no_carry) else $error("normal mode carry active");

endmodule : leac_element

// File: leac_block.sv
// Logic array block of ten elements with carry-select and chain paths.
// Assumes all inputs come from logic on clock_in; none are synchronised.
`timescale 1ns/100ps

module leac_block (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire leac_pkg::leac_mode_e mode_in,
  input wire logic add_subtract_select_in,
  input wire logic [leac_pkg::LEAC_ELEMENTS*leac_pkg::LEAC_MASK_W-1:0] lut_mask_in,
  input wire logic [leac_pkg::LEAC_ELEMENTS*leac_pkg::LEAC_DATA_W-1:0] data_in,
  input wire logic [leac_pkg::LEAC_ELEMENTS-1:0] lut_chain_sel_in,
  input wire logic [leac_pkg::LEAC_ELEMENTS-1:0] pack_en_in,
  input wire logic [leac_pkg::LEAC_ELEMENTS-1:0] reg_chain_sel_in,
  input wire logic [leac_pkg::LEAC_ELEMENTS-1:0] chain_start_in,
  input wire logic lut_chain_in,
  input wire logic reg_chain_in,
  input wire logic block_carry_in,
  output logic [leac_pkg::LEAC_ELEMENTS-1:0] result_comb_out,
  output logic [leac_pkg::LEAC_ELEMENTS-1:0] result_reg_out,
  output logic lut_chain_out,
  output logic reg_chain_out,
  output logic block_carry_out
);

  localparam int NE = leac_pkg::LEAC_ELEMENTS;
  localparam int DW = leac_pkg::LEAC_DATA_W;
  localparam int MW = leac_pkg::LEAC_MASK_W;
  localparam int MID = leac_pkg::LEAC_MID_ELEMENT;
  localparam int LAST = leac_pkg::LEAC_LAST_ELEMENT;

  logic [NE-1:0] lut_res;
  logic [NE-1:0] flop_res;
  logic [NE-1:0] cz_out;
  logic [NE-1:0] c1_out;
  logic [NE-1:0] cz_in;
  logic [NE-1:0] c1_in;
  logic [NE-1:0] lut_cas_in;
  logic [NE-1:0] reg_cas_in;
  logic [NE-1:0] blk_cin;
  logic mid_carry;
  logic end_carry;
  logic [NE-1:0] result_comb_q;
  logic lut_chain_q;
  logic block_carry_q;

  // ****************************************************************
  // Block carry generation at the fifth and tenth elements
  // ****************************************************************
  assign mid_carry = block_carry_in ? c1_out[MID] : cz_out[MID];
  assign end_carry = mid_carry ? c1_out[LAST] : cz_out[LAST];

  // ****************************************************************
  // Ten elements, each with its five chain inputs wired to neighbours
  // ****************************************************************
  generate
    for (genvar i = 0; i < NE; i++) begin : g_elem
      if (i == 0) begin : g_first
        // First element: carry paths start at 0 and 1 under block carry
        assign cz_in[i] = 1'b0;
        assign c1_in[i] = 1'b1;
        assign lut_cas_in[i] = lut_chain_in;
        assign reg_cas_in[i] = reg_chain_in;
        assign blk_cin[i] = block_carry_in;
      end else begin : g_next
        // Carry paths restart at 0 and 1 in the element after the mid element
        assign cz_in[i] = (i == MID + 1) ? 1'b0 : cz_out[i-1];
        assign c1_in[i] = (i == MID + 1) ? 1'b1 : c1_out[i-1];
        assign lut_cas_in[i] = lut_res[i-1];
        assign reg_cas_in[i] = flop_res[i-1];
        assign blk_cin[i] = (i > MID) ? mid_carry : block_carry_in;
      end

      leac_element u_elem (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .clk_en_in(clk_en_in),
        .mode_in(mode_in),
        .sub_in(add_subtract_select_in),
        .lut_mask_in(lut_mask_in[i*MW +: MW]),
        .data_in(data_in[i*DW +: DW]),
        .lut_chain_in(lut_cas_in[i]),
        .lut_chain_sel_in(lut_chain_sel_in[i]),
        .pack_en_in(pack_en_in[i]),
        .reg_chain_in(reg_cas_in[i]),
        .reg_chain_sel_in(reg_chain_sel_in[i]),
        .chain_start_in(chain_start_in[i]),
        .carry_in_zero_path_in(cz_in[i]),
        .carry_in_one_path_in(c1_in[i]),
        .block_carry_in(blk_cin[i]),
        .comb_out(lut_res[i]),
        .reg_out(flop_res[i]),
        .carry_out_zero_path_out(cz_out[i]),
        .carry_out_one_path_out(c1_out[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Output stage
  // ****************************************************************
  // Combinational copy of each table, captured once for the outputs
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_comb_q <= leac_pkg::LEAC_RESULT_RST;
    end else if (clk_en_in) begin
      result_comb_q <= lut_res;
    end
  end

  // Cascade and carry handed to the next block
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lut_chain_q <= leac_pkg::LEAC_FLOP_RST;
      block_carry_q <= leac_pkg::LEAC_FLOP_RST;
    end else if (clk_en_in) begin
      lut_chain_q <= lut_res[LAST];
      block_carry_q <= (mode_in == leac_pkg::LEAC_MODE_ARITH) ? end_carry : 1'b0;
    end
  end

  assign result_comb_out = result_comb_q;
  assign result_reg_out = flop_res;
  assign lut_chain_out = lut_chain_q;
  assign reg_chain_out = flop_res[LAST];
  assign block_carry_out = block_carry_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic arith;
  assign arith = (mode_in == leac_pkg::LEAC_MODE_ARITH);

  // Subtract at a chain start: carry is a | ~b, sum is a ^ b
  property p_sub_first;
    @(posedge clock_in) disable iff (!resetn_in)
      (arith && add_subtract_select_in && chain_start_in[0] && !lut_chain_sel_in[0]) |->
        (cz_out[0] == (data_in[0] | ~data_in[1]) && c1_out[0] == cz_out[0]
         && lut_res[0] == (data_in[0] ^ data_in[1]));
  endproperty
  a_sub_first: assert property (p_sub_first) else $error("subtract start wrong");

  // Add at a chain start: carry is a & b
  property p_add_first;
    @(posedge clock_in) disable iff (!resetn_in)
      (arith && !add_subtract_select_in && chain_start_in[0] && !lut_chain_sel_in[0]) |->
        (cz_out[0] == (data_in[0] & data_in[1]) && c1_out[0] == cz_out[0]);
  endproperty
  a_add_first: assert property (p_add_first) else $error("add start wrong");

  // Without a chain start the carries differ only by the incoming pair
  // Propagate case: A differs from the possibly inverted B
  property p_no_start_carry;
    @(posedge clock_in) disable iff (!resetn_in)
      (arith && !chain_start_in[0] && !lut_chain_sel_in[0]
       && data_in[0] != (data_in[1] ^ add_subtract_select_in)) |->
        (cz_out[0] == 1'b0 && c1_out[0] == 1'b1);
  endproperty
  a_no_start_carry: assert property (p_no_start_carry) else $error("carry pair wrong");

  // Parallel sums: block carry selects the one path
  property p_select;
    @(posedge clock_in) disable iff (!resetn_in)
      (arith && !chain_start_in[1] && !lut_chain_sel_in[1]) |->
        (lut_res[1] == (data_in[DW] ^ data_in[DW+1] ^ add_subtract_select_in
                        ^ (block_carry_in ? c1_out[0] : cz_out[0])));
  endproperty
  a_select: assert property (p_select) else $error("carry select wrong");

  // Upper half sums take their carry from the fifth element
  property p_mid_carry;
    @(posedge clock_in) disable iff (!resetn_in)
      (arith && !lut_chain_sel_in[MID+1]) |->
        (lut_res[MID+1] == (data_in[DW*(MID+1)] ^ data_in[DW*(MID+1)+1]
                            ^ add_subtract_select_in
                            ^ (chain_start_in[MID+1] ? add_subtract_select_in : mid_carry))
         && blk_cin[MID] == block_carry_in);
  endproperty
  a_mid_carry: assert property (p_mid_carry) else $error("mid carry wrong");

  // Comb copy reaches the output one enabled edge later
  property p_comb_copy;
    @(posedge clock_in) disable iff (!resetn_in)
      clk_en_in |=> (result_comb_out == $past(lut_res));
  endproperty
  a_comb_copy: assert property (p_comb_copy) else $error("comb copy lost");

  // Register chain shifts two elements in two enabled edges
  sequence s_shift_setup;
    clk_en_in && reg_chain_sel_in[1] && reg_chain_sel_in[2];
  endsequence
  sequence s_shift_hold;
    clk_en_in && reg_chain_sel_in[2];
  endsequence
  property p_shift;
    @(posedge clock_in) disable iff (!resetn_in)
      (s_shift_setup ##1 s_shift_hold) |=> (result_reg_out[2] == $past(result_reg_out[0], 2));
  endproperty
  a_shift: assert property (p_shift) else $error("register chain broken");

  // Packed flop drives the D input of its own table
  property p_pack;
    @(posedge clock_in) disable iff (!resetn_in)
      (!arith && pack_en_in[0] && !lut_chain_sel_in[0]) |->
        (lut_res[0] == lut_mask_in[{result_reg_out[0], data_in[2:0]}]);
  endproperty
  a_pack: assert property (p_pack) else $error("packing feedback wrong");

  // Table cascade feeds the next element's A input
  property p_cascade;
    @(posedge clock_in) disable iff (!resetn_in)
      (!arith && lut_chain_sel_in[1] && !pack_en_in[1]) |->
        (lut_res[1] == lut_mask_in[MW + 32'({data_in[DW+3:DW+1], lut_res[0]})]);
  endproperty
  a_cascade: assert property (p_cascade) else $error("table cascade wrong");

  // A low enable freezes the element flops, the comb copy and the block carry
  property p_freeze;
    @(posedge clock_in) disable iff (!resetn_in)
      !clk_en_in |=> ($stable(result_reg_out) && $stable(result_comb_out)
                      && $stable(block_carry_out));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule : leac_block

// File: leac_neighbour.sv
// Model of the previous block in the chain: table cascade, flop chain, carry.
// Assumes the shared clock and clear of the block under test.
`timescale 1ns/100ps

module leac_neighbour (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic hold_in,
  output logic lut_chain_out,
  output logic reg_chain_out,
  output logic block_carry_out
);
  // ****************************************************************
  // Pseudo-random chain outputs of the lower block
  // ****************************************************************
  logic [7:0] lfsr_q;

  // Outputs move just after an edge; hold makes the neighbour answer slowly
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lfsr_q <= 8'h5a;
    end else if (!hold_in) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // Three separate taps feed the three chain inputs
  assign lut_chain_out = lfsr_q[0];
  assign reg_chain_out = lfsr_q[3];
  assign block_carry_out = lfsr_q[6];
endmodule : leac_neighbour

// File: leac_block_bench.sv
// Self-checking bench for the logic array block with a reference model.
// Assumes leac_pkg, leac_block and leac_neighbour are compiled first.
`timescale 1ns/100ps

module leac_block_bench;
  localparam int N = leac_pkg::LEAC_ELEMENTS;
  logic clock_in = 1'h0;
  logic resetn_in = 1'h0;
  logic clk_en = 1'h0;
  leac_pkg::leac_mode_e mode = leac_pkg::LEAC_MODE_NORMAL;
  logic sub = 1'h0;
  logic hold = 1'h0;
  logic [16*N-1:0] mask = '0;
  logic [4*N-1:0] data = '0;
  logic [N-1:0] lsel = 10'h000;
  logic [N-1:0] pack = 10'h000;
  logic [N-1:0] rsel = 10'h000;
  logic [N-1:0] cstart = 10'h000;
  logic peer_lut, peer_reg, peer_carry;
  logic [N-1:0] result_comb_out, result_reg_out;
  logic lut_chain_out, reg_chain_out, block_carry_out;
  logic [N-1:0] m_flop = 10'h000;
  logic [N-1:0] m_comb = 10'h000;
  logic m_lut = 1'h0;
  logic m_carry = 1'h0;
  logic [2*N+2:0] exp_q[$];
  int seed = 83;
  int errors = 0;
  int total_checks = 0;
  int k;

  // ****************************************************************
  // Clock, design and neighbour
  // ****************************************************************
  always #5 clock_in = ~clock_in;

  leac_neighbour u_neighbour (.clock_in(clock_in), .resetn_in(resetn_in), .hold_in(hold),
    .lut_chain_out(peer_lut), .reg_chain_out(peer_reg), .block_carry_out(peer_carry));

  leac_block DUT (.clock_in(clock_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
    .mode_in(mode), .add_subtract_select_in(sub), .lut_mask_in(mask), .data_in(data),
    .lut_chain_sel_in(lsel), .pack_en_in(pack), .reg_chain_sel_in(rsel),
    .chain_start_in(cstart), .lut_chain_in(peer_lut), .reg_chain_in(peer_reg),
    .block_carry_in(peer_carry), .result_comb_out(result_comb_out),
    .result_reg_out(result_reg_out), .lut_chain_out(lut_chain_out),
    .reg_chain_out(reg_chain_out), .block_carry_out(block_carry_out));

  // ****************************************************************
  // Reference model: notes the outputs expected after the next edge
  // ****************************************************************
  task automatic predict();
    logic [N-1:0] tab;
    logic [N-1:0] nflop;
    logic [N-1:0] chain;
    logic [3:0] idx;
    logic c;
    logic prev;
    logic b;
    int i;
    c = peer_carry;
    prev = peer_lut;
    chain = {m_flop[N-2:0], peer_reg};
    for (i = 0; i < N; i++) begin
      b = data[4*i+1] ^ sub;
      if (mode == leac_pkg::LEAC_MODE_ARITH) begin
        if (cstart[i]) c = sub;
        tab[i] = data[4*i] ^ b ^ c;
        c = (data[4*i] & b) | (c & (data[4*i] ^ b));
      end else begin
        idx = {pack[i] ? m_flop[i] : data[4*i+3], data[4*i+2], data[4*i+1],
          lsel[i] ? prev : data[4*i]};
        tab[i] = mask[16*i+idx];
      end
      prev = tab[i];
      nflop[i] = rsel[i] ? chain[i] : tab[i];
    end
    if (!resetn_in) begin
      m_flop = 10'h000;
      m_comb = 10'h000;
      m_lut = 1'h0;
      m_carry = 1'h0;
    end else if (clk_en) begin
      m_flop = nflop;
      m_comb = tab;
      m_lut = tab[N-1];
      m_carry = (mode == leac_pkg::LEAC_MODE_ARITH) ? c : 1'h0;
    end
    exp_q.push_back({m_comb, m_flop, m_lut, m_flop[N-1], m_carry});
  endtask : predict

  // Random values for every input but the clear, table cascade off in arithmetic mode, carry chains started sparsely
  task automatic rand_inputs();
    int j;
    for (j = 0; j < 5; j++) mask[32*j +: 32] = $random(seed);
    data[31:0] = $random(seed);
    data[39:32] = 8'($random(seed));
    mode = ($random(seed) & 1) ? leac_pkg::LEAC_MODE_ARITH : leac_pkg::LEAC_MODE_NORMAL;
    sub = 1'($random(seed));
    lsel = (mode == leac_pkg::LEAC_MODE_ARITH) ? 10'h000 : 10'($random(seed));
    pack = 10'($random(seed));
    rsel = 10'($random(seed)) & 10'($random(seed));
    cstart = 10'($random(seed)) & 10'($random(seed)) & 10'($random(seed));
    clk_en = ($random(seed) & 7) != 0;
    hold = ($random(seed) & 3) == 0;
  endtask : rand_inputs

  // Places operands A and B on the first two data inputs of each element
  task automatic set_ab(input logic [N-1:0] a, input logic [N-1:0] b);
    int i;
    for (i = 0; i < N; i++) begin
      data[4*i] = a[i];
      data[4*i+1] = b[i];
    end
  endtask : set_ab

  // ****************************************************************
  // Checking side: oldest note against the outputs after each edge
  // ****************************************************************
  task automatic check_out(input logic [2*N+2:0] exp);
    logic [2*N+2:0] got;
    got = {result_comb_out, result_reg_out, lut_chain_out, reg_chain_out, block_carry_out};
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t outputs %h expected %h", $time, got, exp);
    end
  endtask : check_out

  // Compares once the edge's updates have landed
  always @(posedge clock_in) begin
    #1;
    if (exp_q.size() > 0) check_out(exp_q.pop_front());
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // ****************************************************************
  // Stimulus at the falling edge
  // ****************************************************************
  initial begin
    repeat (20) begin
      @(negedge clock_in);
      predict();
    end
    @(negedge clock_in);
    resetn_in = 1'h1;
    predict();
    // Subtract and add across boundaries, least significant bit in element 0
    for (k = 0; k < 4; k++) begin
      @(negedge clock_in);
      mode = leac_pkg::LEAC_MODE_ARITH;
      cstart = 10'h001;
      clk_en = 1'h1;
      sub = (k % 2) == 0;
      set_ab(k < 2 ? 10'h000 : 10'h155, k == 0 ? 10'h001 : (k == 1 ? 10'h3ff : 10'h2aa));
      predict();
    end
    // Register chain shifts as one long shift register
    for (k = 0; k < 12; k++) begin
      @(negedge clock_in);
      rand_inputs();
      rsel = 10'h3ff;
      clk_en = 1'h1;
      predict();
    end
    // Random traffic with a clear in mid-run
    for (k = 0; k < 400; k++) begin
      @(negedge clock_in);
      rand_inputs();
      if (k >= 200 && k < 204) begin
        resetn_in = k == 203;
        clk_en = 1'h0;
      end
      predict();
    end
    for (k = 0; k < 4 && exp_q.size() > 0; k++) @(negedge clock_in);
    if (exp_q.size() > 0) begin
      errors++;
      $display("[FAIL] %0t results still pending", $time);
    end
    results();
  end
endmodule : leac_block_bench
